// file: core/ufbs_frame_sched.sv
`timescale 1ns/1ps
`include "ufbs_params.svh"
module ufbs_frame_sched #(
  parameter int RAM_WORDS = 2048
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic dataWrite,
  input wire logic dataRead,
  input wire logic [15:0] dataIn,
  output logic [15:0] dataOut,
  input wire logic operational,
  input wire logic sofPulse,
  input wire logic lowSpeed,
  input wire logic [15:0] frameTimeLeft,
  input wire logic descLoad,
  input wire ufbs_pkg::ufbs_load_t descInfo,
  output logic txnStart,
  output ufbs_pkg::ufbs_txn_t txnReq,
  input wire logic txnDone,
  input wire ufbs_pkg::ufbs_result_t txnResult,
  output logic isoCpuHalf,
  output logic frameDeferred
);
  localparam int AW = $clog2(RAM_WORDS);
  localparam int NS = `UFBS_SLOTS;
  logic [15:0] ram [RAM_WORDS];
  logic [7:0] cmd, next_cmd;
  logic wordHi, next_wordHi;
  logic [12:0] bufPtr, next_bufPtr;
  logic [31:0] fmInt, next_fmInt, lsThr, next_lsThr;
  logic [15:0] xferCnt, next_xferCnt, itlLen, next_itlLen, atlLen, next_atlLen;
  logic [2:0] irqFlags, next_irqFlags;
  logic [5:0] stat, next_stat;
  logic [1:0] stuck, next_stuck;
  logic isoWriting, next_isoWriting, atlBusy, next_atlBusy;
  logic next_isoCpuHalf, next_frameDeferred, atlPending, next_atlPending;
  logic isoSeen, next_isoSeen;
  logic [15:0] next_dataOut;
  logic isPort, isItl, access, end_of_transfer, readHalf, schedAllDone;
  logic [12:0] addrByte;
  logic [AW-1:0] ramIdx;
  logic [NS-1:0] active, next_active;
  logic [15:0] remain [NS];
  logic [15:0] next_remain [NS];
  logic [9:0] maxPkt [NS];
  logic [9:0] next_maxPkt [NS];
  ufbs_pkg::ufbs_state_t state, next_state;
  logic next_txnStart, atlLoaded, next_atlLoaded;
  ufbs_pkg::ufbs_txn_t next_txnReq;
  logic [1:0] lastSlot, next_lastSlot;
  logic [15:0] cutoff;
  logic timeOk, canRun;

  // Port decode and RAM addressing; each half sits after the ACKNOWLEDGED_TRANSFER_LIST area.
  always_comb begin
    isPort = cmd[6:0] == `UFBS_IDX_ITLPORT || cmd[6:0] == `UFBS_IDX_ATLPORT;
    isItl = cmd[6:0] == `UFBS_IDX_ITLPORT;
    access = (dataWrite || dataRead) && isPort;
    end_of_transfer = access && ({3'h0, bufPtr} + {3'h0, `UFBS_PTR_STEP} >= xferCnt);
    readHalf = stat[`UFBS_ST_I0D] ? 1'b0 : (stat[`UFBS_ST_I1D] ? 1'b1 : isoCpuHalf);
    addrByte = bufPtr;
    if (isItl) begin
      addrByte = atlLen[12:0] + bufPtr
        + (((cmd[`UFBS_CMD_WR] ? isoCpuHalf : readHalf)) ? itlLen[12:0] : 13'h0000);
    end
    ramIdx = addrByte[AW:1];
  end

  // one word per access, low byte at the even address
  always_ff @(posedge clk) begin
    if (access && dataWrite) begin
      ram[ramIdx] <= dataIn;
    end
  end

  // Bus, flag and ping-pong state. Clears come first so hardware sets win.
  always_comb begin
    next_cmd = cmd;
    next_wordHi = wordHi;
    next_bufPtr = bufPtr;
    next_fmInt = fmInt;
    next_lsThr = lsThr;
    next_xferCnt = xferCnt;
    next_itlLen = itlLen;
    next_atlLen = atlLen;
    next_irqFlags = irqFlags;
    next_stat = stat;
    next_stuck = stuck;
    next_isoWriting = isoWriting;
    next_atlBusy = atlBusy;
    next_isoCpuHalf = isoCpuHalf;
    next_frameDeferred = frameDeferred;
    next_atlPending = atlPending;
    next_isoSeen = isoSeen;
    next_dataOut = dataOut;
    if (cmdWrite) begin
      next_cmd = cmdCode;
      next_wordHi = 1'b0;
      next_bufPtr = 13'h0000;
      next_isoWriting = cmdCode[6:0] == `UFBS_IDX_ITLPORT && cmdCode[`UFBS_CMD_WR];
      next_atlBusy = cmdCode[6:0] == `UFBS_IDX_ATLPORT;
    end else if (dataWrite && !isPort && cmd[`UFBS_CMD_WR]) begin
      next_wordHi = !wordHi;
      unique case (cmd[6:0])
        `UFBS_IDX_FMINT: begin
          if (wordHi) next_fmInt[31:16] = dataIn;
          else next_fmInt[15:0] = dataIn;
        end
        `UFBS_IDX_LSTHR: begin
          if (wordHi) next_lsThr[31:16] = dataIn;
          else next_lsThr[15:0] = dataIn;
        end
        `UFBS_IDX_XFER: next_xferCnt = dataIn;
        `UFBS_IDX_ITLLEN: next_itlLen = dataIn;
        `UFBS_IDX_ATLLEN: next_atlLen = dataIn;
        `UFBS_IDX_IRQ: next_irqFlags = irqFlags & ~dataIn[2:0];
        default: next_wordHi = wordHi;
      endcase
    end else if (dataRead && !isPort) begin
      next_wordHi = !wordHi;
      unique case (cmd[6:0])
        `UFBS_IDX_FMINT: next_dataOut = wordHi ? fmInt[31:16] : fmInt[15:0];
        `UFBS_IDX_LSTHR: next_dataOut = wordHi ? lsThr[31:16] : lsThr[15:0];
        `UFBS_IDX_XFER: next_dataOut = xferCnt;
        `UFBS_IDX_ITLLEN: next_dataOut = itlLen;
        `UFBS_IDX_ATLLEN: next_dataOut = atlLen;
        `UFBS_IDX_IRQ: next_dataOut = {13'h0000, irqFlags};
        `UFBS_IDX_BUFST: next_dataOut = {10'h000, stat};
        default: next_dataOut = 16'h0000;
      endcase
    end
    if (access) begin
      next_bufPtr = end_of_transfer ? 13'h0000 : bufPtr + `UFBS_PTR_STEP;
      if (dataRead) next_dataOut = ram[ramIdx];
    end
    // a word read from a finished half clears both its flags
    if (access && dataRead && isItl && stat[`UFBS_ST_I0D + readHalf]) begin
      next_stat[`UFBS_ST_I0F + readHalf] = 1'b0;
      next_stat[`UFBS_ST_I0D + readHalf] = 1'b0;
    end
    if (end_of_transfer) begin
      next_irqFlags[`UFBS_IRQ_EOT] = 1'b1;
      if (isItl) begin
        next_isoWriting = 1'b0;
        // finished write marks the half full; a stuck half stays empty
        if (dataWrite && !stuck[isoCpuHalf]) next_stat[`UFBS_ST_I0F + isoCpuHalf] = 1'b1;
      end else begin
        next_atlBusy = 1'b0;
        if (dataWrite) begin
          next_stat[`UFBS_ST_AF] = 1'b1;
        end else begin
          next_stat[`UFBS_ST_AF] = 1'b0;
          next_stat[`UFBS_ST_AD] = 1'b0;
        end
      end
    end
    // done only once every descriptor has been serviced
    if (schedAllDone) begin
      next_stat[`UFBS_ST_AD] = 1'b1;
      next_atlPending = 1'b1;
    end
    // ACKNOWLEDGED_TRANSFER_LIST interrupt once the list has been processed
    // it waits until an ISO interrupt has been seen since reset
    // suppressed in a frame that started mid-transfer
    if (atlPending && isoSeen && !frameDeferred) begin
      next_irqFlags[`UFBS_IRQ_ATL] = 1'b1;
      next_atlPending = 1'b0;
    end
    if (sofPulse) begin
      // ISO and ACKNOWLEDGED_TRANSFER_LIST interrupts are separate events
      next_irqFlags[`UFBS_IRQ_ISO] = 1'b1;
      next_isoSeen = 1'b1;
      // a busy processor loses this frame's ACKNOWLEDGED_TRANSFER_LIST work
      next_frameDeferred = atlBusy || isoWriting;
      for (int h = 0; h < 2; h++) begin
        if (stat[`UFBS_ST_I0F + h] && stat[`UFBS_ST_I0D + h]) begin
          // uncleared half is wiped and left stuck
          next_stat[`UFBS_ST_I0F + h] = 1'b0;
          next_stat[`UFBS_ST_I0D + h] = 1'b0;
          next_stuck[h] = 1'b1;
        end else if (h[0] != isoCpuHalf && stat[`UFBS_ST_I0F + h]) begin
          // the half owned by the controller is now processed
          // its done flag appears beside its own full flag, which stays set
          next_stat[`UFBS_ST_I0D + h] = 1'b1;
        end
      end
      // swap unless both are full, then the processor keeps half 1
      if (stat[`UFBS_ST_I0F] && stat[`UFBS_ST_I1F]) next_isoCpuHalf = 1'b1;
      else next_isoCpuHalf = !isoCpuHalf;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd <= 8'h00;
      wordHi <= 1'b0;
      bufPtr <= 13'h0000;
      fmInt <= 32'h00000000;
      lsThr <= 32'h00000000;
      xferCnt <= 16'h0000;
      itlLen <= 16'h0000;
      atlLen <= 16'h0000;
      irqFlags <= 3'h0;
      stat <= 6'h00;
      stuck <= 2'h0;
      isoWriting <= 1'b0;
      atlBusy <= 1'b0;
      isoCpuHalf <= 1'b0;
      frameDeferred <= 1'b0;
      atlPending <= 1'b0;
      isoSeen <= 1'b0;
      dataOut <= 16'h0000;
    end else begin
      cmd <= next_cmd;
      wordHi <= next_wordHi;
      bufPtr <= next_bufPtr;
      fmInt <= next_fmInt;
      lsThr <= next_lsThr;
      xferCnt <= next_xferCnt;
      itlLen <= next_itlLen;
      atlLen <= next_atlLen;
      irqFlags <= next_irqFlags;
      stat <= next_stat;
      stuck <= next_stuck;
      isoWriting <= next_isoWriting;
      atlBusy <= next_atlBusy;
      isoCpuHalf <= next_isoCpuHalf;
      frameDeferred <= next_frameDeferred;
      atlPending <= next_atlPending;
      isoSeen <= next_isoSeen;
      dataOut <= next_dataOut;
    end
  end

  // Descriptor scheduler. Slots are visited round robin so that one large
  // transfer cannot starve the others within a frame.
  always_comb begin
    logic found;
    logic [1:0] s;
    found = 1'b0;
    s = 2'h0;
    next_active = active;
    next_remain = remain;
    next_maxPkt = maxPkt;
    next_state = state;
    next_txnStart = 1'b0;
    next_txnReq = txnReq;
    next_lastSlot = lastSlot;
    next_atlLoaded = atlLoaded;
    // cut-off depends on the speed of the next packet
    cutoff = lowSpeed ? {4'h0, lsThr[`UFBS_LS_HI:`UFBS_LS_LO]}
                      : {1'b0, fmInt[`UFBS_FS_HI:`UFBS_FS_LO]};
    timeOk = frameTimeLeft > cutoff;
    canRun = operational && stat[`UFBS_ST_AF] && !stat[`UFBS_ST_AD] && !frameDeferred && timeOk;
    schedAllDone = atlLoaded && active == '0 && state == ufbs_pkg::UFBS_IDLE
      && operational && stat[`UFBS_ST_AF] && !stat[`UFBS_ST_AD];
    if (schedAllDone) next_atlLoaded = 1'b0;
    if (descLoad) begin
      next_active[descInfo.slot] = descInfo.total != 16'h0000;
      next_remain[descInfo.slot] = descInfo.total;
      next_maxPkt[descInfo.slot] = descInfo.maxPkt;
      next_atlLoaded = 1'b1;
    end
    unique case (state)
      ufbs_pkg::UFBS_IDLE: begin
        // keep searching active slots while frame time remains
        for (int i = 1; i <= NS; i++) begin
          if (!found && active[2'(lastSlot + 2'(i))]) begin
            found = 1'b1;
            s = 2'(lastSlot + 2'(i));
          end
        end
        if (canRun && found) begin
          next_txnStart = 1'b1;
          next_txnReq.slot = s;
          // a count above the packet size is sent in pieces
          next_txnReq.len = remain[s] > {6'h00, maxPkt[s]} ? maxPkt[s] : remain[s][9:0];
          next_lastSlot = s;
          next_state = ufbs_pkg::UFBS_WAIT;
        end
      end
      ufbs_pkg::UFBS_WAIT: begin
        if (txnDone) begin
          // active falls on completion, on a fatal error, or when descLoad reloads the slot with a zero total
          if (txnResult.fatal || remain[txnResult.slot] <= {6'h00, txnResult.bytes}) begin
            next_active[txnResult.slot] = 1'b0;
            next_remain[txnResult.slot] = 16'h0000;
          end else begin
            next_remain[txnResult.slot] = remain[txnResult.slot] - {6'h00, txnResult.bytes};
          end
          next_state = ufbs_pkg::UFBS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active <= '0;
      for (int i = 0; i < NS; i++) begin
        remain[i] <= 16'h0000;
        maxPkt[i] <= 10'h000;
      end
      state <= ufbs_pkg::UFBS_IDLE;
      txnStart <= 1'b0;
      txnReq <= '0;
      lastSlot <= 2'h3;
      atlLoaded <= 1'b0;
    end else begin
      active <= next_active;
      remain <= next_remain;
      maxPkt <= next_maxPkt;
      state <= next_state;
      txnStart <= next_txnStart;
      txnReq <= next_txnReq;
      lastSlot <= next_lastSlot;
      atlLoaded <= next_atlLoaded;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_doneRead;
    access && dataRead && isItl && stat[`UFBS_ST_I0D + readHalf] && !sofPulse;
  endsequence
  property p_isoAtSof;
    sofPulse |=> irqFlags[`UFBS_IRQ_ISO];
  endproperty
  a_isoAtSof: assert property (p_isoAtSof) else $error("ISO flag missing after SOF");
  property p_doneOperational;
    $rose(stat[`UFBS_ST_AD]) |-> $past(operational) && $past(atlLoaded);
  endproperty
  a_doneOperational: assert property (p_doneOperational) else $error("ACKNOWLEDGED_TRANSFER_LIST done too early");
  property p_lenCap;
    txnStart |-> txnReq.len <= maxPkt[txnReq.slot] && txnReq.len != 10'h000;
  endproperty
  a_lenCap: assert property (p_lenCap) else $error("Packet exceeds max size");
  property p_cutoff;
    txnStart |-> $past(timeOk) && !$past(frameDeferred);
  endproperty
  a_cutoff: assert property (p_cutoff) else $error("Packet started past cut-off");
  property p_noAtlIrqDeferred;
    $rose(irqFlags[`UFBS_IRQ_ATL]) |-> !$past(frameDeferred) && $past(isoSeen);
  endproperty
  a_noAtlIrqDeferred: assert property (p_noAtlIrqDeferred) else $error("ACKNOWLEDGED_TRANSFER_LIST irq in deferred frame");
  property p_swapHold;
    sofPulse && stat[`UFBS_ST_I0F] && stat[`UFBS_ST_I1F] |=> isoCpuHalf;
  endproperty
  a_swapHold: assert property (p_swapHold) else $error("Halves swapped while both full");
  property p_readClears;
    logic h;
    (s_doneRead, h = readHalf) |=> !stat[`UFBS_ST_I0F + h] && !stat[`UFBS_ST_I0D + h];
  endproperty
  a_readClears: assert property (p_readClears) else $error("Read did not clear half flags");
  property p_eot;
    end_of_transfer |=> irqFlags[`UFBS_IRQ_EOT] && bufPtr == 13'h0000;
  endproperty
  a_eot: assert property (p_eot) else $error("End-of-transfer not flagged");
  property p_ptrStep;
    access && !end_of_transfer && !cmdWrite |=> bufPtr == $past(bufPtr) + `UFBS_PTR_STEP;
  endproperty
  a_ptrStep: assert property (p_ptrStep) else $error("Pointer did not advance by two");
endmodule

// file: shared/ufbs_params.svh
`ifndef UFBS_PARAMS_SVH
`define UFBS_PARAMS_SVH
// Register indices carried by the command code; bit 7 of the code selects a write.
`define UFBS_IDX_FMINT 7'h0d
`define UFBS_IDX_LSTHR 7'h11
`define UFBS_IDX_XFER 7'h22
`define UFBS_IDX_IRQ 7'h24
`define UFBS_IDX_ITLLEN 7'h2a
`define UFBS_IDX_ATLLEN 7'h2b
`define UFBS_IDX_BUFST 7'h2c
`define UFBS_IDX_ITLPORT 7'h40
`define UFBS_IDX_ATLPORT 7'h41
`define UFBS_CMD_WR 7
// Interrupt flag positions.
`define UFBS_IRQ_ISO 0
`define UFBS_IRQ_ATL 1
`define UFBS_IRQ_EOT 2
// Buffer status positions.
`define UFBS_ST_I0F 0
`define UFBS_ST_I1F 1
`define UFBS_ST_AF 2
`define UFBS_ST_I0D 3
`define UFBS_ST_I1D 4
`define UFBS_ST_AD 5
// Cut-off fields.
`define UFBS_FS_HI 30
`define UFBS_FS_LO 16
`define UFBS_LS_HI 11
`define UFBS_LS_LO 0
`define UFBS_PTR_STEP 13'h0002
`define UFBS_SLOTS 4
`endif

// file: shared/ufbs_pkg.sv
package ufbs_pkg;
  typedef enum logic [1:0] {UFBS_IDLE = 2'b01, UFBS_WAIT = 2'b10} ufbs_state_t;
  typedef struct packed {
    logic [1:0] slot;
    logic [15:0] total;
    logic [9:0] maxPkt;
  } ufbs_load_t;
  typedef struct packed {
    logic [1:0] slot;
    logic [9:0] len;
  } ufbs_txn_t;
  typedef struct packed {
    logic [1:0] slot;
    logic [9:0] bytes;
    logic fatal;
  } ufbs_result_t;
endpackage

// file: bench/ufbs_usb_model.sv
`timescale 1ns/1ps
// Behavioural downstream bus: answers each transaction after a set number of cycles.
module ufbs_usb_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic txnStart,
  input wire ufbs_pkg::ufbs_txn_t txnReq,
  input wire logic [3:0] respDelay,
  input wire logic failNext,
  output logic txnDone,
  output ufbs_pkg::ufbs_result_t txnResult,
  output logic [7:0] startCount,
  output logic [15:0] byteSum
);
  ufbs_pkg::ufbs_txn_t req;

  // Quiet bus until the first transaction, then one transaction at a time.
  // The result lines carry junk outside the done pulse, so a design that
  // samples them late cannot pass by luck.
  initial begin
    txnDone = 1'b0;
    txnResult = '0;
    startCount = 8'h00;
    byteSum = 16'h0000;
    forever begin
      @(posedge clk);
      if (rstn && txnStart) begin
        req = txnReq;
        startCount = startCount + 8'h01;
        byteSum = byteSum + {6'h00, req.len};
        repeat (respDelay) @(posedge clk);
        #1;
        txnResult = '{slot: req.slot, bytes: req.len, fatal: failNext};
        txnDone = 1'b1;
        @(posedge clk);
        #1;
        txnDone = 1'b0;
        txnResult = ~txnResult;
      end
    end
  end
endmodule

// file: bench/usb_host_frame_buffer_scheduler_tb_top.sv
`timescale 1ns/1ps
`include "ufbs_params.svh"
`define CHK(name, exp, got) begin comparisons++; if ((got) !== (exp)) begin errors++; \
  $display("BAD %s exp %h got %h", name, exp, got); end end
module usb_host_frame_buffer_scheduler_tb_top;
  logic clk, rstn, cmdWrite, dataWrite, dataRead, operational, sofPulse, lowSpeed;
  logic descLoad, txnStart, txnDone, isoCpuHalf, frameDeferred, failNext;
  logic [7:0] cmdCode, startCount;
  logic [15:0] dataIn, dataOut, frameTimeLeft, v, byteSum;
  logic [3:0] respDelay;
  ufbs_pkg::ufbs_load_t descInfo;
  ufbs_pkg::ufbs_txn_t txnReq;
  ufbs_pkg::ufbs_result_t txnResult;
  int errors = 0;
  int comparisons = 0;

  ufbs_frame_sched u_dut (.clk(clk), .rstn(rstn), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
    .dataWrite(dataWrite), .dataRead(dataRead), .dataIn(dataIn), .dataOut(dataOut),
    .operational(operational), .sofPulse(sofPulse), .lowSpeed(lowSpeed),
    .frameTimeLeft(frameTimeLeft), .descLoad(descLoad), .descInfo(descInfo),
    .txnStart(txnStart), .txnReq(txnReq), .txnDone(txnDone), .txnResult(txnResult),
    .isoCpuHalf(isoCpuHalf), .frameDeferred(frameDeferred));

  ufbs_usb_model u_usb (.clk(clk), .rstn(rstn), .txnStart(txnStart), .txnReq(txnReq),
    .respDelay(respDelay), .failNext(failNext), .txnDone(txnDone), .txnResult(txnResult),
    .startCount(startCount), .byteSum(byteSum));

  // Free-running 20 MHz clock.
  always #25 clk = ~clk;

  // Every stimulus change lands 1 ns after a rising edge to stay clear of sampling.
  task cyc;
    @(posedge clk);
    #1;
  endtask

  task cmd(input logic [7:0] c);
    cmdCode = c;
    cmdWrite = 1'b1;
    cyc;
    cmdWrite = 1'b0;
  endtask

  // An idle cycle after each strobe keeps back-to-back calls from setting a strobe twice at once.
  task wr(input logic [15:0] d);
    dataIn = d;
    dataWrite = 1'b1;
    cyc;
    dataWrite = 1'b0;
    cyc;
  endtask

  // Read data is registered, so it is taken one cycle after the strobe.
  task rd(output logic [15:0] d);
    dataRead = 1'b1;
    cyc;
    dataRead = 1'b0;
    d = dataOut;
    cyc;
  endtask

  task regWr(input logic [6:0] idx, input logic [15:0] d);
    cmd({1'b1, idx});
    wr(d);
  endtask

  task regRd(input logic [6:0] idx, output logic [15:0] d);
    cmd({1'b0, idx});
    rd(d);
  endtask

  task sof;
    sofPulse = 1'b1;
    cyc;
    sofPulse = 1'b0;
    cyc;
  endtask

  task load(input logic [1:0] s, input logic [15:0] t);
    descInfo = '{slot: s, total: t, maxPkt: 10'h008};
    descLoad = 1'b1;
    cyc;
    descLoad = 1'b0;
  endtask

  task finish_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Polls the status register; a bound that runs out is a failure of its own.
  task waitStatus(input logic [15:0] m);
    int n;
    for (n = 0; n < 60; n++) begin
      regRd(`UFBS_IDX_BUFST, v);
      if ((v & m) === m) break;
    end
    if (n == 60) begin
      errors++;
      finish_test;
    end
  endtask

  // Main sequence: ACKNOWLEDGED_TRANSFER_LIST through the engine, then the ping-pong halves.
  initial begin
    {clk, cmdWrite, dataWrite, dataRead, operational, sofPulse, lowSpeed} = '0;
    {descLoad, failNext, rstn, cmdCode, dataIn} = '0;
    descInfo = '0;
    frameTimeLeft = 16'h0050;
    respDelay = 4'h3;
    repeat (10) cyc;
    rstn = 1'b1;
    cyc;
    regRd(`UFBS_IDX_IRQ, v);
    `CHK("irq reset", 16'h0000, v)
    regRd(`UFBS_IDX_BUFST, v);
    `CHK("status reset", 16'h0000, v)
    regRd(7'h30, v);
    `CHK("unmapped read", 16'h0000, v)
    // Separate areas so the halves never alias the acknowledged list.
    regWr(`UFBS_IDX_ATLLEN, 16'h0800);
    regWr(`UFBS_IDX_ITLLEN, 16'h0400);
    cmd({1'b1, `UFBS_IDX_LSTHR});
    wr(16'h0040);
    wr(16'h0000);
    regRd(`UFBS_IDX_LSTHR, v);
    `CHK("low speed threshold", 16'h0040, v)
    cmd({1'b1, `UFBS_IDX_FMINT});
    wr(16'h0000);
    wr(16'h0100);
    regWr(`UFBS_IDX_XFER, 16'h0008);
    cmd(8'hc1);
    repeat (4) wr(16'h0201);
    regRd(`UFBS_IDX_IRQ, v);
    `CHK("eot irq", 16'h0004, v)
    regRd(`UFBS_IDX_BUFST, v);
    `CHK("atl full not done", 16'h0004, v)
    regWr(`UFBS_IDX_IRQ, 16'h0004);
    regRd(`UFBS_IDX_IRQ, v);
    `CHK("eot cleared", 16'h0000, v)
    operational = 1'b1;
    sof;
    regRd(`UFBS_IDX_IRQ, v);
    `CHK("iso irq at sof", 16'h0001, v)
    load(2'd0, 16'h0010);
    repeat (20) cyc;
    `CHK("no start past cutoff", 8'h00, startCount)
    lowSpeed = 1'b1;
    waitStatus(16'h0020);
    `CHK("packets split", 8'h02, startCount)
    `CHK("bytes moved", 16'h0010, byteSum)
    regRd(`UFBS_IDX_IRQ, v);
    `CHK("iso and atl irq", 16'h0003, v)
    regWr(`UFBS_IDX_IRQ, 16'h0003);
    regRd(`UFBS_IDX_IRQ, v);
    `CHK("irq cleared by processor", 16'h0000, v)
    cmd(8'h41);
    repeat (4) rd(v);
    `CHK("atl read back", 16'h0201, v)
    regRd(`UFBS_IDX_BUFST, v);
    `CHK("atl drained", 16'h0000, v & 16'h0024)
    cmd(8'hc1);
    repeat (4) wr(16'h0201);
    respDelay = 4'h0;
    failNext = 1'b1;
    load(2'd1, 16'h0020);
    repeat (40) cyc;
    `CHK("fatal ends slot", 8'h03, startCount)
    failNext = 1'b0;
    sof;
    `CHK("processor half", 1'b0, isoCpuHalf)
    regWr(`UFBS_IDX_XFER, 16'h0004);
    cmd(8'hc0);
    repeat (2) wr(16'h0403);
    regRd(`UFBS_IDX_BUFST, v);
    `CHK("half0 full", 16'h0001, v & 16'h001b)
    sof;
    `CHK("halves swapped", 1'b1, isoCpuHalf)
    cmd(8'hc0);
    repeat (2) wr(16'h0605);
    sof;
    regRd(`UFBS_IDX_BUFST, v);
    `CHK("half1 full half0 done", 16'h000b, v & 16'h001b)
    `CHK("both full keep half1", 1'b1, isoCpuHalf)
    cmd(8'h40);
    rd(v);
    `CHK("iso half0 data", 16'h0403, v)
    regRd(`UFBS_IDX_BUFST, v);
    `CHK("word read clears half0", 16'h0002, v & 16'h001b)
    regWr(`UFBS_IDX_XFER, 16'h0010);
    cmd(8'hc1);
    wr(16'h0807);
    sof;
    `CHK("atl deferred", 1'b1, frameDeferred)
    sof;
    regRd(`UFBS_IDX_BUFST, v);
    `CHK("half1 done", 16'h0012, v & 16'h001b)
    sof;
    regRd(`UFBS_IDX_BUFST, v);
    `CHK("stuck half wiped", 16'h0000, v & 16'h001b)
    // A second reset in mid-run must clear every flag again.
    rstn = 1'b0;
    repeat (2) cyc;
    rstn = 1'b1;
    cyc;
    `CHK("deferral after reset", 1'b0, frameDeferred)
    regRd(`UFBS_IDX_IRQ, v);
    `CHK("irq after reset", 16'h0000, v)
    regRd(`UFBS_IDX_BUFST, v);
    `CHK("status after reset", 16'h0000, v)
    finish_test;
  end
endmodule
